// ===== hdl/pmla_linear_access.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module pmla_linear_access
    import pmla_pkg::*;
#(
    parameter int PTR_W = PMLA_PTR_W,
    parameter int PAGE_W = PMLA_PAGE_W
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reqValid,
    output logic reqReady,
    input wire pmla_req_t req,
    output logic rdValid,
    output logic [15:0] rdData,
    output logic doneStrobe,
    output logic memReq,
    output pmla_mem_t memCmd,
    input wire logic memAck,
    input wire logic [7:0] memRData,
    input wire logic [15:0] logicalAddr,
    output logic logicalInWindow,
    output logic [PTR_W-1:0] logicalLinear,
    output logic [PTR_W-1:0] linearPointer,
    output logic [PAGE_W-1:0] programPage
);

    // The byte lanes and the nine-bit sign extension are built for a 17-bit
    // pointer and a 3-bit page; other widths are refused rather than served badly.
    if (PTR_W != PMLA_PTR_W || PAGE_W != PMLA_PAGE_W) begin : g_width_check
        $error("pointer or page width not supported by this block");
    end

    ////////////////////////////////////////////////////////////////////////////
    // State. Idle takes requests; the two memory states run one byte each, so a
    // word is two byte handshakes in a row, and the pointer moves only at the end.

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MEM_FIRST,
        ST_MEM_SECOND
    } pmla_state_t;

    pmla_state_t state_ff, nxt_state;
    logic [PTR_W-1:0] ptr_ff, nxt_ptr;
    logic [PAGE_W-1:0] page_ff, nxt_page;
    pmla_req_t op_ff, nxt_op;
    pmla_mem_t mem_ff, nxt_mem;
    logic [15:0] rd_ff, nxt_rd;
    logic rdValid_ff, nxt_rdValid;
    logic done_ff, nxt_done;
    logic [PTR_W-1:0] addOffset;

    // Sign extension of the add-byte value to the pointer width.
    assign addOffset = {{9{req.data[7]}}, req.data[7:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic. One request at a time; memory accesses hold the
    // request port off, which keeps pointer updates strictly ordered.

    always_comb begin
        nxt_state = state_ff;
        nxt_ptr = ptr_ff;
        nxt_page = page_ff;
        nxt_op = op_ff;
        nxt_mem = mem_ff;
        nxt_rd = rd_ff;
        nxt_rdValid = 1'b0;
        nxt_done = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (reqValid) begin
                    nxt_op = req;
                    nxt_done = 1'b1;
                    nxt_rdValid = !req.write;
                    // Register selects finish in one cycle; a read returns the old value, or zero for the add byte.
                    case (req.sel)
                        SEL_PTR_HIGH: begin
                            if (req.write) begin
                                nxt_ptr[PMLA_HIGH_BIT] = req.data[0];
                            end
                            nxt_rd = {15'h0000, ptr_ff[PMLA_HIGH_BIT]};
                        end
                        SEL_PTR_MID: begin
                            if (req.write) begin
                                nxt_ptr[PMLA_MID_LSB +: 8] = req.data[7:0];
                            end
                            nxt_rd = {8'h00, ptr_ff[PMLA_MID_LSB +: 8]};
                        end
                        SEL_PTR_LOW: begin
                            if (req.write) begin
                                nxt_ptr[PMLA_LOW_LSB +: 8] = req.data[7:0];
                            end
                            nxt_rd = {8'h00, ptr_ff[PMLA_LOW_LSB +: 8]};
                        end
                        SEL_ADD_BYTE: begin
                            if (req.write) begin
                                nxt_ptr = ptr_ff + addOffset;
                            end
                            nxt_rd = 16'h0000;
                        end
                        SEL_PAGE: begin
                            if (req.write) begin
                                nxt_page = req.data[PMLA_PAGE_W-1:0];
                            end
                            nxt_rd = {13'h0000, page_ff};
                        end
                        default: begin
                            // Data registers: start a memory access at the pointer.
                            nxt_done = 1'b0;
                            nxt_rdValid = 1'b0;
                            nxt_state = ST_MEM_FIRST;
                            nxt_mem.addr = ptr_ff;
                            nxt_mem.we = req.write;
                            nxt_mem.wdata = (req.sel == SEL_WORD_POSTINC) ?
                                req.data[15:8] : req.data[7:0];
                            nxt_rd = 16'h0000;
                        end
                    endcase
                end
            end
            ST_MEM_FIRST: begin
                if (memAck) begin
                    if (op_ff.sel == SEL_WORD_POSTINC) begin
                        // High byte first, then the following address.
                        nxt_rd = {memRData, 8'h00};
                        nxt_mem.addr = ptr_ff + PMLA_STEP_BYTE;
                        nxt_mem.wdata = op_ff.data[7:0];
                        nxt_state = ST_MEM_SECOND;
                    end else begin
                        nxt_rd = {8'h00, memRData};
                        nxt_rdValid = !op_ff.write;
                        nxt_done = 1'b1;
                        nxt_state = ST_IDLE;
                        // The pointer moves only with the acknowledge, never on the request.
                        if (op_ff.sel == SEL_BYTE_POSTINC) begin
                            nxt_ptr = ptr_ff + PMLA_STEP_BYTE;
                        end
                    end
                end
            end
            ST_MEM_SECOND: begin
                if (memAck) begin
                    nxt_rd = {rd_ff[15:8], memRData};
                    nxt_rdValid = !op_ff.write;
                    nxt_done = 1'b1;
                    nxt_state = ST_IDLE;
                    // The add wraps naturally at the 17-bit width.
                    nxt_ptr = ptr_ff + PMLA_STEP_WORD;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers only; every next value is formed in the process above.
    // Reset puts the page select on two so the low map stays contiguous.

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            ptr_ff <= PMLA_PTR_RESET;
            page_ff <= PMLA_PAGE_RESET;
            op_ff <= '0;
            mem_ff <= '0;
            rd_ff <= 16'h0000;
            rdValid_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ptr_ff <= nxt_ptr;
            page_ff <= nxt_page;
            op_ff <= nxt_op;
            mem_ff <= nxt_mem;
            rd_ff <= nxt_rd;
            rdValid_ff <= nxt_rdValid;
            done_ff <= nxt_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Paging window translation for CPU fetches.
    // Its outputs lag logicalAddr by one clock, since both come from flops.

    pmla_window_map u_window (
        .clk(clk),
        .rst_n(rst_n),
        .page(page_ff),
        .logicalAddr(logicalAddr),
        .inWindow(logicalInWindow),
        .linearAddr(logicalLinear)
    );

    // Outputs. Handshake outputs decode the state flop directly; data outputs
    // are flops, so nothing downstream sees a combinational glitch.
    assign reqReady = (state_ff == ST_IDLE);
    assign memReq = (state_ff != ST_IDLE);
    assign memCmd = mem_ff;
    assign rdValid = rdValid_ff;
    assign rdData = rd_ff;
    assign doneStrobe = done_ff;
    assign linearPointer = ptr_ff;
    assign programPage = page_ff;

endmodule

// ===== hdl/pmla_pkg.sv
package pmla_pkg;

    // Pointer and page geometry.
    localparam int PMLA_PTR_W = 17;
    localparam int PMLA_PAGE_W = 3;
    localparam logic [2:0] PMLA_PAGE_RESET = 3'h2;
    localparam logic [16:0] PMLA_PTR_RESET = 17'h00000;
    localparam logic [15:0] PMLA_WINDOW_BASE = 16'h8000;
    localparam logic [15:0] PMLA_WINDOW_MASK = 16'hc000;
    localparam int PMLA_PAGE_SHIFT = 14;
    localparam logic [16:0] PMLA_STEP_BYTE = 17'h00001;
    localparam logic [16:0] PMLA_STEP_WORD = 17'h00002;

    // Field positions of the pointer bytes.
    localparam int PMLA_HIGH_BIT = 16;
    localparam int PMLA_MID_LSB = 8;
    localparam int PMLA_LOW_LSB = 0;

    // Register selected by a CPU request.
    typedef enum logic [2:0] {
        SEL_PTR_HIGH,
        SEL_PTR_MID,
        SEL_PTR_LOW,
        SEL_BYTE,
        SEL_BYTE_POSTINC,
        SEL_WORD_POSTINC,
        SEL_ADD_BYTE,
        SEL_PAGE
    } pmla_sel_t;

    // One CPU request; word writes use all 16 data bits, the rest the low 8.
    typedef struct packed {
        logic write;
        pmla_sel_t sel;
        logic [15:0] data;
    } pmla_req_t;

    // One byte access to the external memory array.
    typedef struct packed {
        logic [16:0] addr;
        logic we;
        logic [7:0] wdata;
    } pmla_mem_t;

endpackage

// ===== hdl/pmla_window_map.sv
`timescale 1ns/10ps

// Translates a CPU logical address through the paging window.
module pmla_window_map
    import pmla_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [PMLA_PAGE_W-1:0] page,
    input wire logic [15:0] logicalAddr,
    output logic inWindow,
    output logic [PMLA_PTR_W-1:0] linearAddr
);

    logic nxt_inWindow;
    logic [PMLA_PTR_W-1:0] nxt_linearAddr;
    logic inWindow_ff;
    logic [PMLA_PTR_W-1:0] linearAddr_ff;

    // Page p lands at p * 16 KB; the window offset is the address less the base.
    always_comb begin
        nxt_inWindow = (logicalAddr & PMLA_WINDOW_MASK) == PMLA_WINDOW_BASE;
        nxt_linearAddr = {page, 14'h0000} | {3'h0, logicalAddr[13:0]};
    end

    // Registered so that the translated address is a clean flop output.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inWindow_ff <= 1'b0;
            linearAddr_ff <= PMLA_PTR_RESET;
        end else begin
            inWindow_ff <= nxt_inWindow;
            linearAddr_ff <= nxt_linearAddr;
        end
    end

    assign inWindow = inWindow_ff;
    assign linearAddr = linearAddr_ff;

endmodule

// ===== testbench/pmla_asserts.sv
`timescale 1ns/10ps

// Watches the request, memory and window ports of the linear access block.
module pmla_chk
    import pmla_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire pmla_req_t req,
    input wire logic doneStrobe,
    input wire logic memReq,
    input wire pmla_mem_t memCmd,
    input wire logic [15:0] logicalAddr,
    input wire logic logicalInWindow,
    input wire logic [PMLA_PTR_W-1:0] logicalLinear,
    input wire logic [PMLA_PTR_W-1:0] linearPointer,
    input wire logic [PMLA_PAGE_W-1:0] programPage
);
    logic take;
    logic dataSel;
    logic [16:0] startPtr_ff;
    pmla_sel_t startSel_ff;
    // A request is taken on any edge where valid meets ready.
    assign take = reqValid && reqReady;
    assign dataSel = req.sel inside {SEL_BYTE, SEL_BYTE_POSTINC, SEL_WORD_POSTINC};
    // Completions are judged against the pointer as it stood when the request was taken.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            startPtr_ff <= 17'h00000;
            startSel_ff <= SEL_PTR_HIGH;
        end else if (take) begin
            startPtr_ff <= linearPointer;
            startSel_ff <= req.sel;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    reg_done_a: assert property (take && !dataSel |=> doneStrobe)
        else $error("register access did not complete in one cycle");
    ptr_bytes_a: assert property (take && req.write && req.sel == SEL_PTR_LOW
        |=> linearPointer == {$past(linearPointer[16:8]), $past(req.data[7:0])})
        else $error("low pointer byte write wrong");
    ptr_top_a: assert property (take && req.write && req.sel == SEL_PTR_HIGH
        |=> linearPointer[16] == $past(req.data[0])) else $error("pointer top bit wrong");
    plain_keep_a: assert property (take && req.sel == SEL_BYTE
        |=> $stable(linearPointer) [*2]) else $error("plain byte access moved pointer");
    byte_step_a: assert property (doneStrobe && startSel_ff == SEL_BYTE_POSTINC
        |-> linearPointer == startPtr_ff + PMLA_STEP_BYTE) else $error("byte step wrong");
    word_step_a: assert property (doneStrobe && startSel_ff == SEL_WORD_POSTINC
        |-> linearPointer == startPtr_ff + PMLA_STEP_WORD) else $error("word step wrong");
    add_signed_a: assert property (take && req.write && req.sel == SEL_ADD_BYTE
        |=> linearPointer == $past(linearPointer) + {{9{$past(req.data[7])}},
        $past(req.data[7:0])}) else $error("signed add wrong");
    mem_first_a: assert property (take && dataSel
        |=> memReq && memCmd.addr == $past(linearPointer)) else $error("first address wrong");
    page_load_a: assert property (take && req.write && req.sel == SEL_PAGE
        |=> programPage == $past(req.data[2:0])) else $error("page select wrong");
    window_map_a: assert property ($past(rst_n) |->
        logicalInWindow == (($past(logicalAddr) & PMLA_WINDOW_MASK) == PMLA_WINDOW_BASE)
        && (!logicalInWindow || logicalLinear == {$past(programPage), $past(logicalAddr[13:0])}))
        else $error("window translation wrong");
    // Main scenarios that the bench should reach.
    cover property (doneStrobe && startSel_ff == SEL_WORD_POSTINC);
    cover property (take && req.sel == SEL_ADD_BYTE);
    cover property (logicalInWindow);
endmodule

bind pmla_linear_access pmla_chk pmla_chk_inst (.clk, .rst_n, .reqValid, .reqReady, .req,
    .doneStrobe, .memReq, .memCmd, .logicalAddr, .logicalInWindow, .logicalLinear,
    .linearPointer, .programPage);

// ===== testbench/pmla_linear_access_tb_top.sv
`timescale 1ns/10ps

// Drives CPU requests at the falling edge and checks results against worked values.
module pmla_linear_access_tb_top;
    import pmla_pkg::*;
    logic clk = 1'h0, rst_n = 1'h0, reqValid = 1'h0, reqReady, rdValid, doneStrobe, memReq;
    logic memAck, logicalInWindow;
    pmla_req_t req = '0;
    pmla_mem_t memCmd;
    logic [15:0] rdData, rd, logicalAddr = 16'h0000;
    logic [7:0] memRData, d;
    logic [16:0] logicalLinear, linearPointer, e;
    logic [2:0] programPage;
    logic [1:0] waitCycles = 2'h0;
    int n_fail = 0, samples_checked = 0;
    pmla_linear_access pmla_linear_access_inst (.clk, .rst_n, .reqValid, .reqReady, .req,
        .rdValid, .rdData, .doneStrobe, .memReq, .memCmd, .memAck, .memRData, .logicalAddr,
        .logicalInWindow, .logicalLinear, .linearPointer, .programPage);
    pmla_mem_model pmla_mem_model_inst (.clk, .rst_n, .memReq, .memCmd, .waitCycles,
        .memAck, .memRData);
    // Free-running clock at 125 MHz.
    initial begin
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then stops the run.
    task tally_and_finish;
        $display("Counts: %0d checked, %0d failed", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Compares one value and reports a mismatch at once.
    task chk(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One request held until taken; waits, bounded, for completion and keeps read data.
    task acc(input logic w, input pmla_sel_t s, input logic [15:0] dv);
        int i;
        i = 0;
        while (reqReady !== 1'h1 && i < 50) begin
            @(negedge clk);
            i++;
        end
        reqValid = 1'h1;
        req = '{w, s, dv};
        @(negedge clk);
        reqValid = 1'h0;
        while (doneStrobe !== 1'h1 && i < 50) begin
            @(negedge clk);
            i++;
        end
        if (i >= 50) begin
            n_fail++;
            $display("CHECK FAILED at %0t: request never completed", $time);
            tally_and_finish;
        end
        chk({16'h0, rdValid}, {16'h0, !w});
        rd = rdData;
        // One idle edge keeps the next call from re-raising valid in this time step.
        @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence; the slow memory is used for the first two byte reads only.
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'h1;
        chk(linearPointer, 17'h00000);
        chk({14'h0, programPage}, 17'h00002);
        acc(1'h1, SEL_PTR_HIGH, 16'h0001);
        acc(1'h1, SEL_PTR_MID, 16'h0023);
        acc(1'h1, SEL_PTR_LOW, 16'h0045);
        chk(linearPointer, 17'h12345);
        acc(1'h0, SEL_PTR_HIGH, 16'h0000);
        chk({1'h0, rd}, 17'h00001);
        acc(1'h0, SEL_PTR_MID, 16'h0000);
        chk({1'h0, rd}, 17'h00023);
        acc(1'h0, SEL_PTR_LOW, 16'h0000);
        chk({1'h0, rd}, 17'h00045);
        $display("pointer load test done");
        waitCycles = 2'h2;
        acc(1'h0, SEL_BYTE, 16'h0000);
        chk({1'h0, rd}, {9'h0, 8'h45 ^ 8'h5a});
        chk(linearPointer, 17'h12345);
        acc(1'h0, SEL_BYTE_POSTINC, 16'h0000);
        chk({1'h0, rd}, {9'h0, 8'h45 ^ 8'h5a});
        chk(linearPointer, 17'h12346);
        waitCycles = 2'h0;
        acc(1'h1, SEL_PTR_MID, 16'h00ff);
        acc(1'h1, SEL_PTR_LOW, 16'h00ff);
        acc(1'h1, SEL_WORD_POSTINC, 16'hbeef);
        chk(linearPointer, 17'h00001);
        acc(1'h1, SEL_ADD_BYTE, 16'h00fe);
        chk(linearPointer, 17'h1ffff);
        acc(1'h0, SEL_WORD_POSTINC, 16'h0000);
        chk({1'h0, rd}, 17'h0beef);
        chk(linearPointer, 17'h00001);
        acc(1'h1, SEL_BYTE, 16'h003c);
        acc(1'h0, SEL_BYTE, 16'h0000);
        chk({1'h0, rd}, 17'h0003c);
        chk(linearPointer, 17'h00001);
        $display("data access test done");
        e = 17'h00001;
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 8'h7f : 8'h80;
            e = e + {{9{d[7]}}, d};
            acc(1'h1, SEL_ADD_BYTE, {8'h00, d});
            chk(linearPointer, e);
        end
        $display("add byte test done");
        for (int p = 0; p < 8; p++) begin
            acc(1'h1, SEL_PAGE, {13'h0, p[2:0]});
            logicalAddr = {3'h4, p[2:0], 10'h155};
            @(negedge clk);
            chk({16'h0, logicalInWindow}, 17'h00001);
            chk(logicalLinear, {p[2:0], logicalAddr[13:0]});
        end
        logicalAddr = 16'h4000;
        @(negedge clk);
        chk({16'h0, logicalInWindow}, 17'h00000);
        acc(1'h0, SEL_PAGE, 16'h0000);
        chk({1'h0, rd}, 17'h00007);
        $display("window test done");
        tally_and_finish;
    end
endmodule

// ===== testbench/pmla_mem_model.sv
`timescale 1ns/10ps

// Byte memory answering after a chosen wait; an idle data bus shows a changing byte.
module pmla_mem_model
    import pmla_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic memReq,
    input wire pmla_mem_t memCmd,
    input wire logic [1:0] waitCycles,
    output logic memAck,
    output logic [7:0] memRData
);
    bit [7:0] mem [0:131071];
    bit known [0:131071];
    logic [1:0] cnt;
    // Unwritten bytes read as a pattern of their address, so a wrong address shows.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memAck <= 1'h0;
            cnt <= 2'h0;
            memRData <= 8'h00;
        end else if (memReq && memAck) begin
            if (memCmd.we) begin
                mem[memCmd.addr] = memCmd.wdata;
                known[memCmd.addr] = 1'b1;
            end
            memAck <= 1'h0;
            cnt <= 2'h0;
            memRData <= ~memRData;
        end else if (memReq && cnt >= waitCycles) begin
            memAck <= 1'h1;
            memRData <= known[memCmd.addr] ? mem[memCmd.addr] : memCmd.addr[7:0] ^ 8'h5a;
        end else begin
            cnt <= memReq ? cnt + 2'h1 : 2'h0;
            memRData <= ~memRData;
        end
    end
endmodule
